// ---- common/ivmu_pkg.sv ----
package ivmu_pkg;
	// sources covered: irq 45..75, index = irq - first irq
	localparam int IVMU_FIRST_IRQ = 45;
	localparam int IVMU_NUM_SRC = 31;
	localparam int IVMU_NUM_GRP = 12;
	localparam logic [30:0] IVMU_FLAG_RST = 31'h0;
	localparam logic [30:0] IVMU_ENABLE_RST = 31'h0;
	localparam logic [31:0] IVMU_PRIO_RST = 32'h0;
	localparam logic [5:0] IVMU_VEC_NONE = 6'h00;
	// priority group of each source (index 0 = irq 45)
	localparam logic [3:0] IVMU_SRC_GRP [0:30] = '{
		4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
		4'h1, 4'h1,
		4'h2, 4'h2, 4'h2,
		4'h3, 4'h3, 4'h3,
		4'h4, 4'h4, 4'h4,
		4'h5, 4'h5, 4'h5,
		4'h6, 4'h6, 4'h6,
		4'h7, 4'h7, 4'h7,
		4'h8,
		4'h9, 4'ha, 4'hb, 4'hc};
	// vector of each group
	localparam logic [5:0] IVMU_GRP_VEC [0:12] = '{
		6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27,
		6'h28, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d};
	// priority word (8..11) and low bit of 5-bit field in that word
	localparam logic [1:0] IVMU_GRP_WORD [0:12] = '{
		2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1,
		2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
	localparam logic [4:0] IVMU_GRP_LSB [0:12] = '{
		5'h08, 5'h10, 5'h18, 5'h00, 5'h08, 5'h10, 5'h18,
		5'h00, 5'h08, 5'h10, 5'h18, 5'h00, 5'h08};
	// dma channels (irq 72..75) are not persistent
	localparam logic [30:0] IVMU_PERSIST = 31'h07ffffff;
	// flag word bit positions: word 1 bits 13..31 then word 2 bits 0..11
	localparam int IVMU_W1_LSB = 13;
	localparam int IVMU_W1_CNT = 19;
endpackage

// ---- hw/ivmu_prio_pick.sv ----
`timescale 1ns/100ps
module ivmu_prio_pick
	import ivmu_pkg::*;
(
	// candidates
	input wire logic [30:0] active_in,
	input wire logic [4:0] rank_in [0:30],
	// result
	output logic hit_out,
	output logic [4:0] idx_out
);
	// strict greater keeps the lower irq on ties
	always_comb begin
		logic [4:0] best_rank;
		best_rank = 5'h00;
		hit_out = 1'b0;
		idx_out = 5'h00;
		for (int i = 0; i < IVMU_NUM_SRC; i++) begin
			if (active_in[i] && (!hit_out || rank_in[i] > best_rank)) begin
				hit_out = 1'b1;
				best_rank = rank_in[i];
				idx_out = 5'(i);
			end
		end
	end
endmodule // ivmu_prio_pick

// ---- hw/ivmu_top.sv ----
`timescale 1ns/100ps
// Operation
// - port change B..G are irq 45..50, vector 33, flags word1 13..18, prio word8 12:8
// - parallel port event/error are irq 51/52, vector 34, flags word1 19..20
// - second spi fault/rx/tx are irq 53..55, vector 35, prio word8 28:24
// - second uart error/rx/tx are irq 56..58, vector 36, prio word9 4:0
// - second i2c collision/target/controller are irq 59..61, vector 37
// - third uart irq 62..64, vector 38, flags word1 30..31 and word2 0
// - fourth uart irq 65..67, vector 39, flags word2 1..3, prio word9 28:24
// - fifth uart irq 68..70, vector 40, flags word2 4..6, prio word10 4:0
// - dma channels 0..3 are irq 72..75, vectors 42..45, flags word2 8..11
// - dma requests are non-persistent; all other sources are persistent
// - flag reads 1 once its source requested; resets 0; software writable
// - enable 1 permits source, 0 blocks it; resets to 0
module ivmu_top
	import ivmu_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// sources, index 0 = irq 45
	input wire logic [30:0] src_req_in,
	// flag word writes: a strobe per word loads its data into that word
	input wire logic flag1_wr_in,
	input wire logic [31:0] flag1_wdata_in,
	input wire logic flag2_wr_in,
	input wire logic [31:0] flag2_wdata_in,
	// enable word writes
	input wire logic enable1_wr_in,
	input wire logic [31:0] enable1_wdata_in,
	input wire logic enable2_wr_in,
	input wire logic [31:0] enable2_wdata_in,
	// priority words 8..11
	input wire logic [3:0] prio_wr_in,
	input wire logic [31:0] prio_wdata_in,
	// status
	output logic [31:0] flag1_out,
	output logic [31:0] flag2_out,
	output logic [31:0] enable1_out,
	output logic [31:0] enable2_out,
	// core request
	output logic core_req_out,
	output logic [5:0] core_vec_out,
	output logic [2:0] core_prio_out
);
	logic [30:0] flag_ff;
	logic [30:0] enable_ff;
	logic [31:0] prio_ff [0:3];
	logic [30:0] src_prev_ff;
	logic core_req_ff;
	logic [5:0] core_vec_ff;
	logic [2:0] core_prio_ff;

	// unpack word images to per-source vectors
	function automatic logic [30:0] word_to_src(input logic [31:0] w1, input logic [31:0] w2);
		word_to_src = {w2[11:0], w1[31:13]};
	endfunction

	function automatic logic [4:0] grp_field(input logic [31:0] words [0:3], input logic [3:0] g);
		logic [31:0] w;
		w = words[IVMU_GRP_WORD[g]];
		grp_field = 5'(w >> IVMU_GRP_LSB[g]);
	endfunction

	////////////////////////////////////////////////////////////////
	// flags
	wire [30:0] flag_wvalue = word_to_src(flag1_wdata_in, flag2_wdata_in);
	wire [30:0] flag_wmask = {{12{flag2_wr_in}}, {19{flag1_wr_in}}};
	// persistent sources raise on level, dma on rising edge only
	wire [30:0] src_rise = src_req_in & ~src_prev_ff;
	wire [30:0] src_set = (src_req_in & IVMU_PERSIST) | (src_rise & ~IVMU_PERSIST);
	// set wins over a software clear in the same cycle
	wire [30:0] nxt_flag = ((flag_ff & ~flag_wmask) | (flag_wvalue & flag_wmask)) | src_set;
	wire [30:0] enable_wvalue = word_to_src(enable1_wdata_in, enable2_wdata_in);
	wire [30:0] enable_wmask = {{12{enable2_wr_in}}, {19{enable1_wr_in}}};
	wire [30:0] nxt_enable = (enable_ff & ~enable_wmask) | (enable_wvalue & enable_wmask);

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			flag_ff <= IVMU_FLAG_RST;
			enable_ff <= IVMU_ENABLE_RST;
			src_prev_ff <= 31'h0;
		end else begin
			flag_ff <= nxt_flag;
			enable_ff <= nxt_enable;
			src_prev_ff <= src_req_in;
		end
	end

	always_ff @(posedge clk_in) begin
		for (int k = 0; k < 4; k++) begin
			if (!rstn_in) begin
				prio_ff[k] <= IVMU_PRIO_RST;
			end else if (prio_wr_in[k]) begin
				prio_ff[k] <= prio_wdata_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// arbitration
	wire [30:0] active = flag_ff & enable_ff;
	logic [4:0] rank [0:30];
	always_comb begin
		for (int i = 0; i < IVMU_NUM_SRC; i++) begin
			rank[i] = grp_field(prio_ff, IVMU_SRC_GRP[i]);
		end
	end
	wire pick_hit;
	wire [4:0] pick_idx;
	ivmu_prio_pick u_pick (
		.active_in(active),
		.rank_in(rank),
		.hit_out(pick_hit),
		.idx_out(pick_idx)
	);
	wire [3:0] pick_grp = IVMU_SRC_GRP[pick_idx];
	wire [4:0] pick_rank = rank[pick_idx];
	// priority 0 disables the source at the core
	wire nxt_core_req = pick_hit && (pick_rank[4:2] != 3'h0);
	wire [5:0] nxt_core_vec = nxt_core_req ? IVMU_GRP_VEC[pick_grp] : IVMU_VEC_NONE;
	wire [2:0] nxt_core_prio = nxt_core_req ? pick_rank[4:2] : 3'h0;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			core_req_ff <= 1'b0;
			core_vec_ff <= IVMU_VEC_NONE;
			core_prio_ff <= 3'h0;
			flag1_out <= 32'h0;
			flag2_out <= 32'h0;
			enable1_out <= 32'h0;
			enable2_out <= 32'h0;
		end else begin
			core_req_ff <= nxt_core_req;
			core_vec_ff <= nxt_core_vec;
			core_prio_ff <= nxt_core_prio;
			flag1_out <= {nxt_flag[18:0], 13'h0};
			flag2_out <= {20'h0, nxt_flag[30:19]};
			enable1_out <= {nxt_enable[18:0], 13'h0};
			enable2_out <= {20'h0, nxt_enable[30:19]};
		end
	end
	assign core_req_out = core_req_ff;
	assign core_vec_out = core_vec_ff;
	assign core_prio_out = core_prio_ff;

	////////////////////////////////////////////////////////////////
	// checks
	// flag and enable behaviour
	flag_sticky_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(src_req_in[0] ##1 1'b1) |-> flag_ff[0]) else $error("persistent flag missed");
	flag_image_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		flag1_out == {flag_ff[18:0], 13'h0} && flag2_out == {20'h0, flag_ff[30:19]})
		else $error("flag word image wrong");
	persist_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		src_req_in[26] |=> flag_ff[26]) else $error("persistent source not flagged");
	dma_edge_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		($past(src_req_in[27]) && src_req_in[27] && flag2_wr_in && !flag2_wdata_in[8]) |=> !flag_ff[27])
		else $error("dma flag set by level");
	dma_rise_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(!$past(src_req_in[30]) && src_req_in[30]) |=> flag_ff[30]) else $error("dma edge missed");
	enable_reset_a: assert property (@(posedge clk_in)
		!rstn_in |=> enable_ff == 31'h0) else $error("enable not cleared");
	enable_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(!enable1_wr_in && !enable2_wr_in) |=> $stable(enable_ff)) else $error("enable changed without write");
	enable_block_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(enable_ff == 31'h0) |=> !core_req_ff) else $error("request with all sources blocked");
	// vector map; priority compared against the word as it stood when the choice was made
	cn_vec_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h00000001 && prio_ff[0][12:10] != 3'h0)
		|=> core_vec_ff == 6'h21 && core_prio_ff == $past(prio_ff[0][12:10]))
		else $error("port change vector wrong");
	cn_last_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h00000020 && prio_ff[0][12:10] != 3'h0) |=> core_vec_ff == 6'h21)
		else $error("last port change vector wrong");
	pport_vec_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h00000040 && prio_ff[0][20:18] != 3'h0) |=> core_vec_ff == 6'h22)
		else $error("parallel port vector wrong");
	pport_err_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h00000080 && prio_ff[0][20:18] != 3'h0) |=> core_vec_ff == 6'h22)
		else $error("parallel port error vector wrong");
	spi_vec_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h00000100 && prio_ff[0][28:26] != 3'h0) |=> core_vec_ff == 6'h23)
		else $error("second spi vector wrong");
	uart2_vec_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h00000800 && prio_ff[1][4:2] != 3'h0) |=> core_vec_ff == 6'h24)
		else $error("second uart vector wrong");
	i2c_vec_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h00004000 && prio_ff[1][12:10] != 3'h0) |=> core_vec_ff == 6'h25)
		else $error("second i2c vector wrong");
	uart3_low_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h00040000 && prio_ff[1][20:18] != 3'h0) |=> core_vec_ff == 6'h26)
		else $error("third uart low word vector wrong");
	uart3_split_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h00080000 && prio_ff[1][20:18] != 3'h0) |=> core_vec_ff == 6'h26)
		else $error("third uart vector wrong");
	uart4_vec_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h00100000 && prio_ff[1][28:26] != 3'h0) |=> core_vec_ff == 6'h27)
		else $error("fourth uart vector wrong");
	uart5_vec_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h00800000 && prio_ff[2][4:2] != 3'h0) |=> core_vec_ff == 6'h28)
		else $error("fifth uart vector wrong");
	dma_zero_vec_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h08000000 && prio_ff[2][20:18] != 3'h0) |=> core_vec_ff == 6'h2a)
		else $error("first dma vector wrong");
	dma3_vec_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h40000000 && prio_ff[3][12:10] != 3'h0) |=> core_vec_ff == 6'h2d)
		else $error("dma3 vector wrong");
	// core request
	req_needs_en_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		core_req_ff |-> $past(active) != 31'h0) else $error("request without enabled flag");
	req_prio_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		core_req_ff |-> core_prio_ff != 3'h0) else $error("request at priority zero");
	idle_vec_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!core_req_ff |-> (core_vec_ff == IVMU_VEC_NONE && core_prio_ff == 3'h0)) else $error("idle vector not cleared");
	// dma2 and dma3 fields both live in the last priority word
	tie_low_irq_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(active == 31'h60000000 && prio_ff[3][4:0] == prio_ff[3][12:8] && prio_ff[3][12:10] != 3'h0)
		|=> core_vec_ff == 6'h2c) else $error("tie not by natural order");
endmodule // ivmu_top

// ---- testbench/ivmu_src_model.sv ----
`timescale 1ns/100ps
module ivmu_src_model
	import ivmu_pkg::*;
(
	// held levels and one-cycle strobes from the bench
	input wire logic [30:0] lvl_in,
	input wire logic [30:0] pls_in,
	// request lines into the block
	output logic [30:0] src_req_out
);
	// a strobed line drops after one cycle whether serviced or not, so no settling to a fixed level here
	assign src_req_out = lvl_in | pls_in;
endmodule // ivmu_src_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
// look at outputs mid-cycle, away from the edge that updates them
`define CHK(g, e) begin @(negedge clk_in); checks_done++; \
	if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t %h %h", $time, g, e); end end
module tb_top;
	import ivmu_pkg::*;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [30:0] lvl = 31'h0;
	logic [30:0] pls = 31'h0;
	logic [30:0] src;
	logic f1w = 1'b0, f2w = 1'b0, e1w = 1'b0, e2w = 1'b0;
	logic [31:0] f1d = 32'h0, f2d = 32'h0, e1d = 32'h0, e2d = 32'h0, pd = 32'h0;
	logic [3:0] pw = 4'h0;
	logic [31:0] f1o, f2o, e1o, e2o;
	logic req;
	logic [5:0] vec;
	logic [2:0] pri;
	int error_cnt = 0;
	int checks_done = 0;
	// first irq, last irq, vector of each group
	int rows [0:12][0:2] = '{'{45, 50, 33}, '{51, 52, 34}, '{53, 55, 35}, '{56, 58, 36}, '{59, 61, 37},
		'{62, 64, 38}, '{65, 67, 39}, '{68, 70, 40}, '{71, 71, 41}, '{72, 72, 42}, '{73, 73, 43},
		'{74, 74, 44}, '{75, 75, 45}};
	initial forever #50 clk_in = ~clk_in;
	ivmu_src_model src_m (.lvl_in(lvl), .pls_in(pls), .src_req_out(src));
	ivmu_top DUT (.clk_in(clk_in), .rstn_in(rstn_in), .src_req_in(src),
		.flag1_wr_in(f1w), .flag1_wdata_in(f1d), .flag2_wr_in(f2w), .flag2_wdata_in(f2d),
		.enable1_wr_in(e1w), .enable1_wdata_in(e1d), .enable2_wr_in(e2w), .enable2_wdata_in(e2d),
		.prio_wr_in(pw), .prio_wdata_in(pd), .flag1_out(f1o), .flag2_out(f2o),
		.enable1_out(e1o), .enable2_out(e2o), .core_req_out(req), .core_vec_out(vec), .core_prio_out(pri));
	////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic wr(input logic fm, input logic em, input logic [3:0] pm, input logic [31:0] d1, input logic [31:0] d2);
		@(posedge clk_in);
		{f1w, f2w, e1w, e2w, pw} <= {fm, fm, em, em, pm};
		{f1d, e1d, pd} <= {d1, d1, d1};
		{f2d, e2d} <= {d2, d2};
		@(posedge clk_in);
		{f1w, f2w, e1w, e2w, pw} <= 8'h00;
		tick(3);
	endtask
	// one-cycle strobe, then long enough for the flag and the core request to land
	task automatic fire(input logic [30:0] m);
		@(posedge clk_in);
		pls <= m;
		@(posedge clk_in);
		pls <= 31'h0;
		tick(3);
	endtask
	task automatic summarize;
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		tick(20000);
		error_cnt++;
		summarize;
	end
	////////////////////////////////////////
	initial begin
		tick(16);
		rstn_in <= 1'b1;
		tick(1);
		`CHK({f1o, f2o, e1o, e2o, req, vec, pri}, 138'h0)
		wr(1'b0, 1'b1, 4'hf, 32'hffffffff, 32'hffffffff);
		`CHK({e1o, e2o}, {32'hffffe000, 32'h00000fff})
		foreach (rows[r]) for (int q = rows[r][0]; q <= rows[r][1]; q++) begin
			fire(31'h1 << (q - 45));
			`CHK({f2o, f1o}, 64'h1 << (q - 32))
			`CHK({req, vec, pri}, {1'b1, 6'(rows[r][2]), 3'h7})
			wr(1'b1, 1'b0, 4'h0, 32'h0, 32'h0);
		end
		fire(31'h60000000);
		`CHK({req, vec}, {1'b1, 6'h2c})
		// subpriority decides before natural order does
		wr(1'b0, 1'b0, 4'h8, 32'h00001f1e, 32'h0);
		`CHK({req, vec, pri}, {1'b1, 6'h2d, 3'h7})
		wr(1'b1, 1'b0, 4'h0, 32'h0, 32'h0);
		wr(1'b0, 1'b0, 4'h8, 32'hffffffff, 32'h0);
		fire(31'h40000001);
		`CHK({req, vec}, {1'b1, 6'h21})
		wr(1'b0, 1'b0, 4'h1, 32'h00000400, 32'h0);
		`CHK({req, vec, pri}, {1'b1, 6'h2d, 3'h7})
		wr(1'b0, 1'b1, 4'h0, 32'hffffffff, 32'h000007ff);
		`CHK({req, vec, pri}, {1'b1, 6'h21, 3'h1})
		// priority zero keeps a flagged, enabled source away from the core
		wr(1'b0, 1'b0, 4'h1, 32'h0, 32'h0);
		`CHK(req, 1'b0)
		wr(1'b1, 1'b0, 4'h0, 32'h0, 32'h0);
		@(posedge clk_in);
		lvl <= 31'h08000001;
		tick(3);
		wr(1'b1, 1'b0, 4'h0, 32'h0, 32'h0);
		`CHK({f1o[13], f2o[8]}, 2'b10)
		wr(1'b1, 1'b0, 4'h0, 32'h0, 32'h00000800);
		`CHK(f2o, 32'h00000800)
		@(posedge clk_in);
		rstn_in <= 1'b0;
		tick(2);
		`CHK({f1o, f2o, e1o, req}, 97'h0)
		summarize;
	end
endmodule // tb_top
